// ### common/lccr_pkg.sv
// constants and carrier types for the per-channel coding and alarm enable registers
package lccr_pkg;

  // ********************************************
  // geometry
  // ********************************************
  localparam int          NUM_CH    = 14;
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 8;
  localparam logic [7:0]  CH_STRIDE = 8'h10;

  // ********************************************
  // register offsets of channel 0 and reset values
  // ********************************************
  localparam logic [7:0]  CODING_OFS = 8'h03;
  localparam logic [7:0]  IRQEN_OFS  = 8'h04;
  localparam logic [7:0]  CODING_RST = 8'h00;
  localparam logic [7:0]  IRQEN_RST  = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD = 8'h00;

  // ********************************************
  // rx resistor field rx_ext_resistor_sel
  // ********************************************
  localparam logic [1:0]  RES_NONE = 2'h0;
  localparam logic [1:0]  RES_240  = 2'h1;
  localparam logic [1:0]  RES_210  = 2'h2;
  localparam logic [1:0]  RES_150  = 2'h3;

  // ********************************************
  // field layouts, msb first
  // ********************************************
  typedef struct packed {
    logic [1:0] rsvd;
    logic       line_code_select;
    logic [1:0] rx_ext_resistor_sel;
    logic       inject_polarity_violation;
    logic       inject_bit_error;
    logic       tx_transformer_ratio_sel;
  } lccr_coding_t;

  typedef struct packed {
    logic       rsvd;
    logic       driver_monitor_irq_en;
    logic       fifo_limit_irq_en;
    logic       code_violation_overflow_irq_en;
    logic [3:0] low_bits;
  } lccr_irqen_t;

  typedef struct packed {
    logic driver_fail_flag;
    logic fifo_limit_flag;
    logic code_violation_flag;
  } lccr_alarm_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lccr_ubus_t;

  typedef struct packed {
    logic       ami_en;
    logic       zs_en;
    logic [1:0] rx_ext_resistor_sel;
    logic       ratio_1to2;
  } lccr_chcfg_t;

endpackage

// ### design/lccr_err_insert.sv
// tx clock edge detection and one-shot error insertion for one channel
`timescale 1ns/100ps
module lccr_err_insert
  import lccr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // tx clock pin and requests from the register
  input  wire logic       tx_line_clock,
  input  wire logic [1:0] req,
  // insertion pulses, bit 1 polarity violation, bit 0 bit error
  output logic      [1:0] ins
);

  // ********************************************
  // pin synchroniser and edge detect
  // ********************************************
  logic       tx_line_clock_s1;
  logic       tx_line_clock_s2;
  logic       tx_line_clock_s3;
  logic       tx_line_clock_rise;
  logic [1:0] sampled;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      tx_line_clock_s1 <= 1'b0;
      tx_line_clock_s2 <= 1'b0;
      tx_line_clock_s3 <= 1'b0;
    end
    else
    begin
      tx_line_clock_s1 <= tx_line_clock;
      tx_line_clock_s2 <= tx_line_clock_s1;
      tx_line_clock_s3 <= tx_line_clock_s2;
    end

  assign tx_line_clock_rise = tx_line_clock_s2 && !tx_line_clock_s3;

  // ********************************************
  // request sampling on the tx clock edge
  // ********************************************
  // requests only advance on a tx edge, so a 0 written and rewritten to 1 between edges is missed
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      sampled <= 2'h0;
    else if (tx_line_clock_rise)
      sampled <= req;                                        // [R6] [R16]

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      ins <= 2'h0;
    else
      ins <= {2{tx_line_clock_rise}} & req & ~sampled;                // [R4] [R5] [R16]

  // ********************************************
  // checks
  // ********************************************
  property p_one_shot(int b);
    @(posedge clk) disable iff (!nrst) ins[b] |=> !ins[b] ##1 !ins[b];
  endproperty

  ber_one_shot_a: assert property (p_one_shot(0)) else $error("bit error pulse repeated");  // [R5]
  bpv_one_shot_a: assert property (p_one_shot(1)) else $error("violation pulse repeated");  // [R4]
  ins_on_edge_a: assert property (@(posedge clk) disable iff (!nrst)               // [R6]
    ins != 2'h0 |-> $past(tx_line_clock_s2) && !$past(tx_line_clock_s3) && $past(tx_line_clock_s3, 2) == 1'b0)
    else $error("insertion without tx edge");
  ins_cover_c: cover property (@(posedge clk) disable iff (!nrst) ins[0] ##[1:40] ins[1]);

endmodule

// ### design/lccr_regs.sv
// per-channel line coding control and upper alarm enable registers
//
// Operation
// R1: each of 14 channels has its own coding register, at 0x03 for channel 0 up to 0xD3 for channel 13.
// R2: in single rail mode the code select bit picks HDB3/B8ZS at 0 and AMI at 1.
// R3: a two-bit field picks the external rx resistor: none, 240, 210 or 150 ohm.
// R4: a rising edge of the violation insert bit puts one bipolar violation in the test pattern.
// R5: a rising edge of the bit error insert bit puts one bit error in the test pattern.
// R6: both insert bits are sampled on rising edges of the transmit clock.
// R7: software writes 0 before 1 to an insert bit so that each request is a clean rising edge.
// R8: with external termination the ratio bit picks 1:2 at 1 and 1:2.45 at 0.
// R9: with internal termination the ratio is fixed at 1:2 and the ratio bit is ignored.
// R10: the driver monitor enable masks that interrupt at 0 and allows it at 1.
// R11: the fifo limit enable masks that interrupt at 0 and allows it at 1.
// R12: the code violation/overflow enable masks that interrupt at 0 and allows it at 1.
// R13: the two upper coding bits are plain read/write storage that clear on reset.
// R14: the interrupt pin asserts only while the global enable is also set.
// R15: each channel requests when any alarm flag meets its enable, and the pin is gated globally.
// R16: insert bits are synchronised to the transmit clock and give exactly one error per rising edge; the code misses a 0-then-1 rewrite between tx edges.
`timescale 1ns/100ps
module lccr_regs
  import lccr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // microprocessor port
  input  wire lccr_ubus_t  ubus,
  output logic [7:0]       rdata,
  output logic             rd_ack,
  // per-channel modes and the global interrupt enable from other registers
  input  wire logic [13:0] ext_term_mode,
  input  wire logic [13:0] single_rail_mode,
  input  wire logic        global_irq_en,
  // alarms and tx clocks
  input  wire lccr_alarm_t alarm         [NUM_CH],
  input  wire logic [13:0] tx_line_clock,
  // line path controls
  output lccr_chcfg_t      chcfg         [NUM_CH],
  output logic [13:0]      ins_polarity_violation,
  output logic [13:0]      ins_bit_error,
  // interrupts
  output logic [13:0]      chan_irq,
  output logic             irq_req
);

  // ********************************************
  // storage
  // ********************************************
  lccr_coding_t coding      [NUM_CH];
  lccr_irqen_t  irqen       [NUM_CH];
  logic [13:0]  next_chan_irq;
  logic [7:0]   next_rdata;

  // ********************************************
  // per-channel registers and line controls
  // ********************************************
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    localparam logic [7:0] A_CODING = 8'(CODING_OFS + ch * CH_STRIDE);
    localparam logic [7:0] A_IRQEN  = 8'(IRQEN_OFS + ch * CH_STRIDE);
    logic [1:0] ins;

    always_ff @(posedge clk or negedge nrst)
      if (!nrst)
        coding[ch] <= CODING_RST;                            // [R13]
      else if (ubus.wr && ubus.addr == A_CODING)
        coding[ch] <= ubus.wdata;                            // [R1] [R13]

    always_ff @(posedge clk or negedge nrst)
      if (!nrst)
        irqen[ch] <= IRQEN_RST;
      else if (ubus.wr && ubus.addr == A_IRQEN)
        irqen[ch] <= ubus.wdata;

    always_ff @(posedge clk or negedge nrst)
      if (!nrst)
        chcfg[ch] <= '0;
      else
      begin
        chcfg[ch].ami_en <= single_rail_mode[ch] && coding[ch].line_code_select;   // [R2]
        chcfg[ch].zs_en <= single_rail_mode[ch] && !coding[ch].line_code_select;   // [R2]
        chcfg[ch].rx_ext_resistor_sel <= coding[ch].rx_ext_resistor_sel;           // [R3]
        // internal termination forces 1:2 regardless of the stored bit
        chcfg[ch].ratio_1to2 <= !ext_term_mode[ch] || coding[ch].tx_transformer_ratio_sel; // [R8] [R9]
      end

    always_comb
      next_chan_irq[ch] = (alarm[ch].driver_fail_flag && irqen[ch].driver_monitor_irq_en)   // [R10] [R15]
                       || (alarm[ch].fifo_limit_flag && irqen[ch].fifo_limit_irq_en)        // [R11] [R15]
                       || (alarm[ch].code_violation_flag
                           && irqen[ch].code_violation_overflow_irq_en);                    // [R12] [R15]

    // relies on software writing 0 before 1 so each request is a real edge
    lccr_err_insert u_ins                                    // [R7]
    (
      .clk           (clk),
      .nrst          (nrst),
      .tx_line_clock (tx_line_clock[ch]),
      .req           ({coding[ch].inject_polarity_violation, coding[ch].inject_bit_error}),
      .ins           (ins)
    );

    assign ins_polarity_violation[ch] = ins[1];              // [R4]
    assign ins_bit_error[ch]          = ins[0];              // [R5]
  end

  // ********************************************
  // interrupt output
  // ********************************************
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      chan_irq <= 14'h0000;
    else
      chan_irq <= next_chan_irq;                             // [R15]

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      irq_req <= 1'b0;
    else
      irq_req <= global_irq_en && (|next_chan_irq);          // [R14] [R15]

  // ********************************************
  // read path
  // ********************************************
  // unmapped addresses read zero so a scan of the whole space is harmless
  always_comb
  begin
    next_rdata = UNMAPPED_RD;
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      if (ubus.addr == 8'(CODING_OFS + ch * CH_STRIDE))
        next_rdata = coding[ch];                             // [R1]
      if (ubus.addr == 8'(IRQEN_OFS + ch * CH_STRIDE))
        next_rdata = irqen[ch];
    end
  end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      rdata <= 8'h00;
    else if (ubus.rd)
      rdata <= next_rdata;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      rd_ack <= 1'b0;
    else
      rd_ack <= ubus.rd;

  // ********************************************
  // checks
  // ********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  last_ch_write_a: assert property (ubus.wr && ubus.addr == 8'hD3 |=> coding[13] == $past(ubus.wdata)) // [R1]
    else $error("channel 13 coding write lost");
  readback_a: assert property (ubus.wr && ubus.addr == 8'h03 ##1 !ubus.wr ##1 ubus.rd && ubus.addr == 8'h03 // [R13]
    && !ubus.wr |=> rd_ack && rdata == $past(ubus.wdata, 3))
    else $error("coding readback mismatch");
  gap_read_a: assert property (ubus.rd && ubus.addr == 8'h13 + 8'h10 * 8'h0D |=> rdata == 8'h00) // [R1]
    else $error("unmapped read not zero");
  code_sel_a: assert property (single_rail_mode[0] && coding[0].line_code_select              // [R2]
    |=> chcfg[0].ami_en && !chcfg[0].zs_en)
    else $error("ami not selected");
  res_sel_a: assert property (##1 chcfg[5].rx_ext_resistor_sel == $past(coding[5].rx_ext_resistor_sel)) // [R3]
    else $error("resistor field not passed");
  ratio_ext_a: assert property (ext_term_mode[7]                                              // [R8]
    |=> chcfg[7].ratio_1to2 == $past(coding[7].tx_transformer_ratio_sel))
    else $error("external ratio wrong");
  ratio_int_a: assert property (!ext_term_mode[7] |=> chcfg[7].ratio_1to2) // [R9]
    else $error("internal ratio not 1:2");
  irq_mask_a: assert property (alarm[3].fifo_limit_flag && !irqen[3].fifo_limit_irq_en        // [R11]
    && !alarm[3].driver_fail_flag && !alarm[3].code_violation_flag |=> !chan_irq[3])
    else $error("masked alarm raised request");
  irq_drv_a: assert property (alarm[3].driver_fail_flag && irqen[3].driver_monitor_irq_en     // [R10]
    |=> chan_irq[3])
    else $error("enabled driver alarm ignored");
  irq_cv_a: assert property (alarm[3].code_violation_flag && irqen[3].code_violation_overflow_irq_en // [R12]
    && global_irq_en |=> irq_req)
    else $error("enabled violation alarm ignored");
  irq_gate_a: assert property (!global_irq_en |=> !irq_req) // [R14]
    else $error("pin without global enable");

  wr_cover_c: cover property (ubus.wr && ubus.addr == 8'hD3);
  irq_cover_c: cover property (!irq_req ##1 irq_req);
  bpv_cover_c: cover property (ins_polarity_violation[0]);

endmodule

// ### bench/tb.sv
// self-checking bench for the coding control and alarm enable registers
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module tb
  import lccr_pkg::*;
;
  // ***************************************
  // signals
  // ***************************************
  logic             clk;
  logic             nrst;
  lccr_ubus_t       ubus;
  logic [7:0]       rdata;
  logic             rd_ack;
  logic [13:0]      ext_term_mode;
  logic [13:0]      single_rail_mode;
  logic             global_irq_en;
  lccr_alarm_t      alarm [NUM_CH];
  logic [13:0]      tx_line_clock;
  lccr_chcfg_t      chcfg [NUM_CH];
  logic [13:0]      ins_polarity_violation;
  logic [13:0]      ins_bit_error;
  logic [13:0]      chan_irq;
  logic             irq_req;
  int               n_mismatch;
  int               samples_checked;
  int               n_bpv;
  int               n_ber;

  lccr_regs u_lccr_regs (
    .clk                    (clk),
    .nrst                   (nrst),
    .ubus                   (ubus),
    .rdata                  (rdata),
    .rd_ack                 (rd_ack),
    .ext_term_mode          (ext_term_mode),
    .single_rail_mode       (single_rail_mode),
    .global_irq_en          (global_irq_en),
    .alarm                  (alarm),
    .tx_line_clock          (tx_line_clock),
    .chcfg                  (chcfg),
    .ins_polarity_violation (ins_polarity_violation),
    .ins_bit_error          (ins_bit_error),
    .chan_irq               (chan_irq),
    .irq_req                (irq_req)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // pulses counted every cycle so a double pulse is seen
  always @(posedge clk)
  begin
    n_bpv += $countones(ins_polarity_violation);
    n_ber += $countones(ins_bit_error);
  end

  // ***************************************
  // access tasks
  // ***************************************
  function automatic logic [7:0] caddr(int ch, logic [7:0] ofs);
    return 8'(ofs + CH_STRIDE * ch);
  endfunction

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    #1;
    ubus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    ubus.wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    int i;
    @(posedge clk);
    #1;
    ubus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    ubus.rd = 1'b0;
    for (i = 0; i < 4 && rd_ack !== 1'b1; i++)
      @(posedge clk) #1;
    if (i == 4)
    begin
      n_mismatch++;
      conclude();
    end
    else
      `CHK(rdata, e)
  endtask

  // slow tx clock cycle, low and high well above two clk periods
  task automatic tick(int ch);
    repeat (4) @(posedge clk);
    #1 tx_line_clock[ch] = 1'b1;
    repeat (4) @(posedge clk);
    #1 tx_line_clock[ch] = 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ***************************************
  // main sequence
  // ***************************************
  initial
  begin
    nrst = 1'b0;
    ubus = '0;
    ext_term_mode = '0;
    single_rail_mode = '1;
    global_irq_en = 1'b0;
    tx_line_clock = '0;
    n_mismatch = 0;
    samples_checked = 0;
    n_bpv = 0;
    n_ber = 0;
    foreach (alarm[i]) alarm[i] = '0;
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    // reset values and channel map
    `CHK(chcfg[0], 5'h09)
    for (int c = 0; c < NUM_CH; c++)
    begin
      rd(caddr(c, CODING_OFS), CODING_RST);
      rd(caddr(c, IRQEN_OFS), IRQEN_RST);
    end
    for (int c = 0; c < NUM_CH; c++)
    begin
      wr(caddr(c, CODING_OFS), {4'(c), 4'h9});
      wr(caddr(c, IRQEN_OFS), ~{4'(c), 4'h6});
    end
    wr(8'hE3, 8'hFF);
    for (int c = 0; c < NUM_CH; c++)
    begin
      rd(caddr(c, CODING_OFS), {4'(c), 4'h9});
      rd(caddr(c, IRQEN_OFS), ~{4'(c), 4'h6});
    end
    rd(8'hE3, UNMAPPED_RD);
    rd(8'h05, UNMAPPED_RD);
    // ami select and reserved bits on channel 0, read back after one idle cycle
    wr(caddr(0, CODING_OFS), 8'hA5);
    rd(caddr(0, CODING_OFS), 8'hA5);
    `CHK(chcfg[0], 5'h11)
    $display("test map done");
    // every resistor code, both line line_code_select, both ratio settings
    for (int k = 0; k < 8; k++)
    begin
      ext_term_mode[7] = k[1];
      wr(caddr(7, CODING_OFS), {2'h3, k[0], k[1:0], 2'h0, k[2]});
      repeat (2) @(posedge clk);
      #1;
      `CHK(chcfg[7], {k[0], ~k[0], k[1:0], ~k[1] | k[2]})
    end
    $display("test coding done");
    // one-shot insertion on the tx clock
    wr(caddr(5, CODING_OFS), 8'h00);
    tick(5);
    wr(caddr(5, CODING_OFS), 8'h02);
    n_bpv = 0;
    n_ber = 0;
    tick(5);
    `CHK(n_ber, 1)
    tick(5);
    `CHK(n_ber, 1)
    wr(caddr(5, CODING_OFS), 8'h04);
    tick(5);
    `CHK(n_bpv, 1)
    // zero then one with no tx edge between is not seen
    wr(caddr(5, CODING_OFS), 8'h00);
    wr(caddr(5, CODING_OFS), 8'h04);
    tick(5);
    `CHK(n_bpv, 1)
    repeat (40) @(posedge clk);
    #1;
    `CHK(n_ber + n_bpv, 2)
    $display("test insert done");
    // each alarm against its own enable and the global gate
    for (int f = 0; f < 3; f++)
    begin
      for (int m = 0; m < 4; m++)
      begin
        alarm[3] = 3'(1 << f);
        global_irq_en = m[0];
        wr(caddr(3, IRQEN_OFS), m[1] ? 8'(8'h10 << f) : 8'(8'h10 << ((f + 1) % 3)));
        repeat (2) @(posedge clk);
        #1;
        `CHK(chan_irq[3], m[1])
        `CHK(irq_req, m[1] & m[0])
      end
    end
    $display("test irq done");
    conclude();
  end
endmodule
